/* File: src/timer_pkg.sv */
// Constants, register map and carrier types for the waveform and capture timer
package timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CONTROL_A     = 5'h00;
  localparam logic [4:0] IDX_CONTROL_B_CLR = 5'h04;
  localparam logic [4:0] IDX_CONTROL_B_SET = 5'h05;
  localparam logic [4:0] IDX_CONTROL_C     = 5'h06;
  localparam logic [4:0] IDX_EVENT_CONTROL = 5'h0a;
  localparam logic [4:0] IDX_INT_FLAGS     = 5'h0e;
  localparam logic [4:0] IDX_STATUS        = 5'h0f;
  localparam logic [4:0] IDX_COUNT         = 5'h10;
  localparam logic [4:0] IDX_PERIOD        = 5'h14;
  localparam logic [4:0] IDX_CC0           = 5'h18;
  localparam logic [4:0] IDX_CC1           = 5'h19;

  // Field positions
  localparam int CA_SOFTWARE_RESET_BIT = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_WAVE_LSB = 5;
  localparam int CA_PRESC_LSB = 8;
  localparam int CA_RUN_IN_STANDBY = 11;
  localparam int CB_DIR = 0;
  localparam int CB_SINGLE_RUN_ENABLE = 2;
  localparam int CB_CMD_LSB = 6;
  localparam int CC_INV_LSB = 0;
  localparam int CC_CPT_LSB = 4;
  localparam int EV_ACT_LSB = 0;
  localparam int EV_INVERT = 4;
  localparam int EV_INPUT_EN = 5;
  localparam int EV_OVFEO = 8;
  localparam int EV_MCEO_LSB = 12;
  localparam int IF_OVF = 0;
  localparam int IF_ERR = 1;
  localparam int IF_MC_LSB = 4;
  localparam int ST_STOP = 3;
  localparam int ST_SYNCBUSY = 7;

  // Encodings
  localparam logic [1:0] WAVE_NORMAL_FREQUENCY_MODE = 2'h0;
  localparam logic [1:0] WAVE_MATCH_FREQUENCY_MODE = 2'h1;
  localparam logic [1:0] WAVE_NORMAL_PWM_MODE = 2'h2;
  localparam logic [1:0] WAVE_MATCH_PWM_MODE = 2'h3;
  localparam logic [2:0] EVENT_ACTION_SELECT_OFF = 3'h0;
  localparam logic [2:0] EVENT_ACTION_SELECT_RETRIGGER = 3'h1;
  localparam logic [2:0] EVENT_ACTION_SELECT_COUNT = 3'h2;
  localparam logic [2:0] EVENT_ACTION_SELECT_START = 3'h3;
  localparam logic [2:0] EVENT_ACTION_SELECT_PPW = 3'h5;
  localparam logic [2:0] EVENT_ACTION_SELECT_PWP = 3'h6;
  localparam logic [1:0] CMD_RETRIGGER = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values and counts
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [2:0] SYNC_CYCLES = 3'h3;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  typedef enum logic {st_stopped, st_running} run_state_type;

endpackage

/* File: src/timer_pwm_capture_single_run_enable.sv */
// Timer counter with PWM, frequency, input capture, one-shot and register sync
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module timer_pwm_capture_single_run_enable
  import timer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire axi_req_type axi_req,
  output axi_rsp_type      axi_rsp,
  input  wire logic        event_pulse,
  input  wire logic        event_level,
  input  wire logic        standby,
  output logic [1:0]       waveform_output,
  output logic             overflow_event,
  output logic [1:0]       match_event
);

  typedef struct packed {
    axi_rsp_type   rsp;
    logic          aw_have;
    logic [7:0]    aw_addr;
    logic          w_have;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          enable;
    logic          run_in_standby;
    logic [2:0]    prescaler;
    logic [1:0]    wavegen;
    logic          dir;
    logic          single_run_enable;
    logic [1:0]    inven;
    logic [1:0]    capture_channel_enable;
    logic [2:0]    event_action_select;
    logic          event_input_invert;
    logic          event_input_enable;
    logic [1:0]    mceo;
    logic          ovfeo;
    logic          overflow_flag;
    logic          error_flag;
    logic [1:0]    match_capture_flag;
    run_state_type run;
    logic          stopped;
    logic [7:0]    count;
    logic [7:0]    period_value;
    logic [7:0]    cc0;
    logic [7:0]    cc1;
    logic [9:0]    presc;
    logic [1:0]    wo;
    logic [1:0]    wo_out;
    logic          ovf_ev;
    logic [1:0]    mc_ev;
    logic [2:0]    sync_cnt;
    logic [4:0]    pend_idx;
    logic [7:0]    pend_data;
  } state_type;

  state_type state_reg;
  state_type state_next;

  function automatic logic addr_mapped(input logic [7:0] a);
    logic [4:0] i;
    i = a[6:2];
    addr_mapped = (a[1:0] == 2'h0) && !a[7] &&
                  (i == IDX_CONTROL_A || i == IDX_CONTROL_B_CLR || i == IDX_CONTROL_B_SET ||
                   i == IDX_CONTROL_C || i == IDX_EVENT_CONTROL || i == IDX_INT_FLAGS ||
                   i == IDX_STATUS || i == IDX_COUNT || i == IDX_PERIOD ||
                   i == IDX_CC0 || i == IDX_CC1);
  endfunction

  function automatic logic is_synced(input logic [4:0] i);
    is_synced = (i == IDX_CONTROL_B_CLR || i == IDX_CONTROL_B_SET || i == IDX_CONTROL_C ||
                 i == IDX_COUNT || i == IDX_PERIOD || i == IDX_CC0 || i == IDX_CC1);
  endfunction

  // Last prescaler count before a tick
  function automatic logic [9:0] presc_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    presc_limit = 10'h000;
      3'h1:    presc_limit = 10'h001;
      3'h2:    presc_limit = 10'h003;
      3'h3:    presc_limit = 10'h007;
      3'h4:    presc_limit = 10'h00f;
      3'h5:    presc_limit = 10'h03f;
      3'h6:    presc_limit = 10'h0ff;
      default: presc_limit = 10'h3ff;
    endcase
  endfunction

  always_comb begin
    logic        do_write;
    logic [4:0]  widx;
    logic [4:0]  ridx;
    logic [31:0] rd;
    logic        apply;
    logic [7:0]  pd;
    logic        cmd_retrig;
    logic        cmd_stop;
    logic        en_start;
    logic        ev;
    logic        ev_retrig;
    logic        ev_start;
    logic        halted;
    logic [7:0]  top;
    logic [7:0]  start_val;
    logic        presc_tick;
    logic        tick;
    logic        wrap;
    logic [1:0]  hit;
    logic [1:0]  cap;
    logic        two_edge;
    logic        restart_edge;
    logic        period_ch;
    logic        pwm_ch0;
    do_write = 1'b0;
    widx = state_reg.aw_addr[6:2];
    ridx = axi_req.araddr[6:2];
    rd = 32'h0000_0000;
    apply = (state_reg.sync_cnt == 3'h1);
    pd = state_reg.pend_data;
    cmd_retrig = 1'b0;
    cmd_stop = 1'b0;
    en_start = 1'b0;
    halted = 1'b0;
    top = 8'h00;
    start_val = 8'h00;
    presc_tick = 1'b0;
    tick = 1'b0;
    wrap = 1'b0;
    hit = 2'h0;
    cap = 2'h0;
    two_edge = 1'b0;
    restart_edge = 1'b0;
    period_ch = 1'b0;
    pwm_ch0 = 1'b0;
    ev = 1'b0;
    ev_retrig = 1'b0;
    ev_start = 1'b0;
    state_next = state_reg;
    state_next.ovf_ev = 1'b0;
    state_next.mc_ev = 2'h0;

    // Write address and data are taken independently, in either order
    if (axi_req.awvalid && state_reg.rsp.awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_reg.rsp.wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = axi_req.wdata;
      state_next.w_strb = axi_req.wstrb;
    end
    if (state_reg.rsp.bvalid && axi_req.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end
    do_write = state_reg.aw_have && state_reg.w_have && !state_reg.rsp.bvalid;
    if (do_write) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = addr_mapped(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Flags cleared by writing one; hardware sets below win in the same cycle
    if (do_write && addr_mapped(state_reg.aw_addr) && state_reg.w_strb[0]) begin
      case (widx)
        IDX_CONTROL_A: begin
          state_next.wavegen = state_reg.w_data[CA_WAVE_LSB +: 2];
          if (state_reg.w_data[CA_SOFTWARE_RESET_BIT] || state_reg.w_data[CA_ENABLE] != state_reg.enable) begin
            state_next.pend_idx = widx;
            state_next.pend_data = state_reg.w_data[7:0];
            state_next.sync_cnt = SYNC_CYCLES;
          end
        end
        IDX_EVENT_CONTROL: begin
          state_next.event_action_select = state_reg.w_data[EV_ACT_LSB +: 3];
          state_next.event_input_invert = state_reg.w_data[EV_INVERT];
          state_next.event_input_enable = state_reg.w_data[EV_INPUT_EN];
        end
        IDX_INT_FLAGS: begin
          if (state_reg.w_data[IF_OVF]) begin
            state_next.overflow_flag = 1'b0;
          end
          if (state_reg.w_data[IF_ERR]) begin
            state_next.error_flag = 1'b0;
          end
          state_next.match_capture_flag = state_reg.match_capture_flag &
                                          ~state_reg.w_data[IF_MC_LSB +: 2];
        end
        default: begin
          if (is_synced(widx)) begin
            state_next.pend_idx = widx;
            state_next.pend_data = state_reg.w_data[7:0];
            state_next.sync_cnt = SYNC_CYCLES;
          end
        end
      endcase
    end
    if (do_write && addr_mapped(state_reg.aw_addr) && state_reg.w_strb[1]) begin
      if (widx == IDX_CONTROL_A) begin
        state_next.prescaler = state_reg.w_data[CA_PRESC_LSB +: 3];
        state_next.run_in_standby = state_reg.w_data[CA_RUN_IN_STANDBY];
      end
      if (widx == IDX_EVENT_CONTROL) begin
        state_next.ovfeo = state_reg.w_data[EV_OVFEO];
        state_next.mceo = state_reg.w_data[EV_MCEO_LSB +: 2];
      end
    end

    // Read channel: data one cycle after the address is taken
    if (state_reg.rsp.rvalid && axi_req.rready) begin
      state_next.rsp.rvalid = 1'b0;
      state_next.rsp.arready = 1'b1;
    end
    if (axi_req.arvalid && state_reg.rsp.arready) begin
      case (ridx)
        IDX_CONTROL_A: begin
          rd[CA_ENABLE] = state_reg.enable;
          rd[CA_WAVE_LSB +: 2] = state_reg.wavegen;
          rd[CA_PRESC_LSB +: 3] = state_reg.prescaler;
          rd[CA_RUN_IN_STANDBY] = state_reg.run_in_standby;
        end
        IDX_CONTROL_B_CLR, IDX_CONTROL_B_SET: begin
          rd[CB_DIR] = state_reg.dir;
          rd[CB_SINGLE_RUN_ENABLE] = state_reg.single_run_enable;
        end
        IDX_CONTROL_C: begin
          rd[CC_INV_LSB +: 2] = state_reg.inven;
          rd[CC_CPT_LSB +: 2] = state_reg.capture_channel_enable;
        end
        IDX_EVENT_CONTROL: begin
          rd[EV_ACT_LSB +: 3] = state_reg.event_action_select;
          rd[EV_INVERT] = state_reg.event_input_invert;
          rd[EV_INPUT_EN] = state_reg.event_input_enable;
          rd[EV_OVFEO] = state_reg.ovfeo;
          rd[EV_MCEO_LSB +: 2] = state_reg.mceo;
        end
        IDX_INT_FLAGS: begin
          rd[IF_OVF] = state_reg.overflow_flag;
          rd[IF_ERR] = state_reg.error_flag;
          rd[IF_MC_LSB +: 2] = state_reg.match_capture_flag;
        end
        IDX_STATUS: begin
          rd[ST_STOP] = state_reg.stopped;
          rd[ST_SYNCBUSY] = (state_reg.sync_cnt != 3'h0);
        end
        IDX_COUNT:  rd[7:0] = state_reg.count;
        IDX_PERIOD: rd[7:0] = state_reg.period_value;
        IDX_CC0:    rd[7:0] = state_reg.cc0;
        IDX_CC1:    rd[7:0] = state_reg.cc1;
        default:    rd = 32'h0000_0000;
      endcase
      state_next.rsp.arready = 1'b0;
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rdata = addr_mapped(axi_req.araddr) ? rd : 32'h0000_0000;
      state_next.rsp.rresp = addr_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    state_next.rsp.awready = !state_next.aw_have;
    state_next.rsp.wready = !state_next.w_have;

    // Synchronised writes land after a fixed delay; busy shows meanwhile
    if (state_reg.sync_cnt != 3'h0) begin
      state_next.sync_cnt = 3'(state_reg.sync_cnt - 3'h1);
    end
    if (apply) begin
      case (state_reg.pend_idx)
        IDX_CONTROL_A: begin
          state_next.enable = pd[CA_ENABLE];
          en_start = pd[CA_ENABLE] && !state_reg.enable &&
                     state_reg.event_action_select != EVENT_ACTION_SELECT_RETRIGGER;
        end
        IDX_CONTROL_B_SET: begin
          state_next.dir = state_reg.dir | pd[CB_DIR];
          state_next.single_run_enable = state_reg.single_run_enable | pd[CB_SINGLE_RUN_ENABLE];
          cmd_retrig = (pd[CB_CMD_LSB +: 2] == CMD_RETRIGGER);
          cmd_stop = (pd[CB_CMD_LSB +: 2] == CMD_STOP);
        end
        IDX_CONTROL_B_CLR: begin
          state_next.dir = state_reg.dir & ~pd[CB_DIR];
          state_next.single_run_enable = state_reg.single_run_enable & ~pd[CB_SINGLE_RUN_ENABLE];
        end
        IDX_CONTROL_C: begin
          state_next.inven = pd[CC_INV_LSB +: 2];
          state_next.capture_channel_enable = pd[CC_CPT_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Counter domain
    halted = standby && !state_reg.run_in_standby;
    top = (state_reg.wavegen == WAVE_NORMAL_FREQUENCY_MODE || state_reg.wavegen == WAVE_NORMAL_PWM_MODE) ?
          state_reg.period_value : state_reg.cc0;
    start_val = state_reg.dir ? top : 8'h00;
    ev = event_pulse && state_reg.event_input_enable;
    ev_retrig = ev && state_reg.event_action_select == EVENT_ACTION_SELECT_RETRIGGER;
    ev_start = ev && state_reg.event_action_select == EVENT_ACTION_SELECT_START;
    two_edge = state_reg.event_action_select == EVENT_ACTION_SELECT_PPW ||
               state_reg.event_action_select == EVENT_ACTION_SELECT_PWP;
    pwm_ch0 = state_reg.wavegen == WAVE_NORMAL_PWM_MODE;

    if (state_reg.run == st_running && !halted) begin
      if (state_reg.presc == presc_limit(state_reg.prescaler)) begin
        state_next.presc = 10'h000;
        presc_tick = 1'b1;
      end else begin
        state_next.presc = 10'(state_reg.presc + 10'h001);
      end
    end
    // Count events bypass the prescaler
    tick = state_reg.run == st_running && !halted && state_reg.enable &&
           (state_reg.event_action_select == EVENT_ACTION_SELECT_COUNT ? ev : presc_tick);

    if (state_reg.wavegen == WAVE_MATCH_PWM_MODE) begin
      state_next.wo[0] = 1'b1;
    end
    if (tick) begin
      hit[0] = state_reg.count == state_reg.cc0;
      hit[1] = state_reg.count == state_reg.cc1;
      if (!state_reg.dir) begin
        wrap = state_reg.count >= top;
        state_next.count = wrap ? 8'h00 : 8'(state_reg.count + 8'h01);
      end else begin
        wrap = state_reg.count == 8'h00;
        // Reload uses the top already landed, so a late write costs one period
        state_next.count = wrap ? top : 8'(state_reg.count - 8'h01);
      end
      if (wrap) begin
        state_next.overflow_flag = 1'b1;
        state_next.ovf_ev = state_reg.ovfeo;
      end
      for (int i = 0; i < 2; i++) begin
        if (hit[i] && !state_reg.capture_channel_enable[i]) begin
          state_next.match_capture_flag[i] = 1'b1;
          state_next.mc_ev[i] = state_reg.mceo[i];
        end
      end
      case (state_reg.wavegen)
        WAVE_NORMAL_PWM_MODE, WAVE_MATCH_PWM_MODE: begin
          if (!state_reg.dir) begin
            if (wrap) begin
              state_next.wo[1] = 1'b1;
            end
            if (hit[1]) begin
              state_next.wo[1] = 1'b0;
            end
            if (pwm_ch0 && wrap) begin
              state_next.wo[0] = 1'b1;
            end
            if (pwm_ch0 && hit[0]) begin
              state_next.wo[0] = 1'b0;
            end
          end else begin
            if (wrap) begin
              state_next.wo[1] = 1'b0;
            end
            if (hit[1]) begin
              state_next.wo[1] = 1'b1;
            end
            if (pwm_ch0 && wrap) begin
              state_next.wo[0] = 1'b0;
            end
            if (pwm_ch0 && hit[0]) begin
              state_next.wo[0] = 1'b1;
            end
          end
          if (!pwm_ch0 && wrap) begin
            state_next.wo[0] = 1'b0;
          end
        end
        default: begin
          state_next.wo = state_reg.wo ^ hit;
        end
      endcase
      if (wrap && state_reg.single_run_enable) begin
        state_next.run = st_stopped;
        state_next.stopped = 1'b1;
      end
    end

    // Commands and event actions
    if (state_reg.run == st_stopped) begin
      if (cmd_retrig || ev_retrig || ev_start || en_start) begin
        state_next.run = st_running;
        state_next.stopped = 1'b0;
        // PWM outputs take their start level at once, not at the first wrap
        if (pwm_ch0 || state_reg.wavegen == WAVE_MATCH_PWM_MODE) begin
          state_next.wo[1] = !state_reg.dir;
        end
        if (pwm_ch0) begin
          state_next.wo[0] = !state_reg.dir;
        end
      end
    end else if (cmd_retrig || ev_retrig) begin
      state_next.count = start_val;
      state_next.presc = 10'h000;
    end
    if (cmd_stop && state_reg.run == st_running) begin
      state_next.run = st_stopped;
      state_next.stopped = 1'b1;
      state_next.count = start_val;
    end
    if (!state_next.enable) begin
      state_next.run = st_stopped;
    end

    // Capture
    if (ev && two_edge) begin
      restart_edge = event_level ^ state_reg.event_input_invert;
      period_ch = state_reg.event_action_select == EVENT_ACTION_SELECT_PWP;
      cap[period_ch] = restart_edge;
      cap[~period_ch] = !restart_edge;
      if (restart_edge) begin
        state_next.count = 8'h00;
      end
    end else if (ev && state_reg.event_action_select == EVENT_ACTION_SELECT_OFF) begin
      cap = 2'h3;
    end
    cap = cap & state_reg.capture_channel_enable;
    for (int i = 0; i < 2; i++) begin
      if (cap[i]) begin
        if (state_reg.match_capture_flag[i]) begin
          state_next.error_flag = 1'b1;
        end else begin
          state_next.match_capture_flag[i] = 1'b1;
          state_next.mc_ev[i] = state_reg.mceo[i];
          if (i == 0) begin
            state_next.cc0 = state_reg.count;
          end else begin
            state_next.cc1 = state_reg.count;
          end
        end
      end
    end

    // Landed data writes take priority over counting and capture
    if (apply) begin
      case (state_reg.pend_idx)
        IDX_COUNT:  state_next.count = pd;
        IDX_PERIOD: state_next.period_value = pd;
        IDX_CC0:    state_next.cc0 = pd;
        IDX_CC1:    state_next.cc1 = pd;
        default: begin
        end
      endcase
      if (state_reg.pend_idx == IDX_CONTROL_A && pd[CA_SOFTWARE_RESET_BIT]) begin
        state_next.enable = 1'b0;
        state_next.run_in_standby = 1'b0;
        state_next.prescaler = 3'h0;
        state_next.wavegen = WAVE_NORMAL_FREQUENCY_MODE;
        state_next.dir = 1'b0;
        state_next.single_run_enable = 1'b0;
        state_next.inven = 2'h0;
        state_next.capture_channel_enable = 2'h0;
        state_next.event_action_select = EVENT_ACTION_SELECT_OFF;
        state_next.event_input_invert = 1'b0;
        state_next.event_input_enable = 1'b0;
        state_next.mceo = 2'h0;
        state_next.ovfeo = 1'b0;
        state_next.overflow_flag = 1'b0;
        state_next.error_flag = 1'b0;
        state_next.match_capture_flag = 2'h0;
        state_next.run = st_stopped;
        state_next.count = 8'h00;
        state_next.period_value = PERIOD_RESET;
        state_next.cc0 = 8'h00;
        state_next.cc1 = 8'h00;
        state_next.presc = 10'h000;
      end
    end

    // Stopped counter drives both waveform outputs low, inversion included
    if (state_next.run == st_stopped) begin
      state_next.wo = 2'h0;
      state_next.wo_out = 2'h0;
    end else begin
      state_next.wo_out = state_next.wo ^ state_next.inven;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.rsp.awready <= 1'b1;
      state_reg.rsp.wready <= 1'b1;
      state_reg.rsp.arready <= 1'b1;
      state_reg.period_value <= PERIOD_RESET;
      state_reg.run <= st_stopped;
    end else begin
      state_reg <= state_next;
    end
  end

  assign axi_rsp = state_reg.rsp;
  assign waveform_output = state_reg.wo_out;
  assign overflow_event = state_reg.ovf_ev;
  assign match_event = state_reg.mc_ev;

endmodule

/* File: dv/timer_checker.sv */
// Bus timing checks for the timer register port
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire axi_req_type axi_req,
  input wire axi_rsp_type axi_rsp,
  input wire logic        event_pulse,
  input wire logic        event_level,
  input wire logic        standby,
  input wire logic [1:0]  waveform_output,
  input wire logic        overflow_event,
  input wire logic [1:0]  match_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence aw_taken;
    axi_req.awvalid && axi_rsp.awready;
  endsequence
  sequence both_taken;
    aw_taken ##0 (axi_req.wvalid && axi_rsp.wready);
  endsequence
  chk_b_after_write: assert property (both_taken |-> ##2 axi_rsp.bvalid)
    else $error("write response late");
  chk_aw_blocked: assert property (aw_taken |=> !axi_rsp.awready)
    else $error("address ready during write");
  chk_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped");
  chk_b_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  chk_r_prompt: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data late");
  chk_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data changed");
  chk_r_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read data repeated");
  chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address ready during read");
endmodule
bind timer_pwm_capture_single_run_enable timer_checker chk(.sys_clk, .rst_b, .axi_req, .axi_rsp,
  .event_pulse, .event_level, .standby, .waveform_output, .overflow_event, .match_event);

/* File: dv/event_source.sv */
// Event routing network model: one registered pulse with its source level
`timescale 1ns/1ps
module event_source (
  input  wire logic sys_clk,
  input  wire logic fire,
  input  wire logic lvl,
  output logic      event_pulse,
  output logic      event_level
);
  // Only this path reaches the timer event input
  always_ff @(posedge sys_clk) begin
    event_pulse <= fire;
    event_level <= lvl;
  end
endmodule

/* File: dv/tb_top.sv */
// Register-level bench for the waveform and capture timer
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic        sys_clk = 0, rst_b = 0, fire = 0, lvl = 0, standby = 0;
  axi_req_type req = '0;
  axi_rsp_type rsp;
  logic        event_pulse, event_level, overflow_event;
  logic [1:0]  waveform_output, match_event, r;
  logic [31:0] d;
  int          fail_count = 0, total_checks = 0, cyc = 0, n = 0;
  timer_pwm_capture_single_run_enable dut(.sys_clk, .rst_b, .axi_req(req), .axi_rsp(rsp), .event_pulse,
    .event_level, .standby, .waveform_output, .overflow_event, .match_event);
  event_source evs(.sys_clk, .fire, .lvl, .event_pulse, .event_level);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ad(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction
  // Each access lets one edge pass first, so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [4:0] i, input logic [31:0] v);
    @(posedge sys_clk);
    req.awvalid <= 1'h1;
    req.awaddr  <= ad(i);
    req.wvalid  <= 1'h1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (!rsp.bvalid);
    req.bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'h1;
    req.araddr  <= a;
    req.rready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'h0;
  endtask
  // Synced writes replace a pending one, so every synced write except the enable write waits here
  task automatic wsync(input logic [4:0] i, input logic [31:0] v);
    wr(i, v);
    do rd(ad(IDX_STATUS)); while (d[ST_SYNCBUSY]);
  endtask
  task automatic fire_ev(input logic level);
    fire <= 1'h1;
    lvl  <= level;
    @(posedge sys_clk);
    fire <= 1'h0;
  endtask
  task automatic pulse();
    fire_ev(1'h0);
    repeat (3) @(posedge sys_clk);
    rd(ad(IDX_INT_FLAGS));
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    rd(ad(IDX_PERIOD));
    check(d, {24'h0, PERIOD_RESET});
    rd(8'h08);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wsync(IDX_PERIOD, 32'h3f);
    rd(ad(IDX_PERIOD));
    check(d, 32'h3f);
    $display("test register access done");
    wsync(IDX_CC0, 32'h10);
    wsync(IDX_CONTROL_B_SET, 32'h4);
    wr(IDX_CONTROL_A, 32'h42);
    repeat (200) @(posedge sys_clk);
    rd(ad(IDX_STATUS));
    check({31'h0, d[ST_STOP]}, 32'h1);
    check({30'h0, waveform_output}, 32'h0);
    wsync(IDX_CONTROL_B_SET, 32'h40);
    rd(ad(IDX_STATUS));
    check({31'h0, d[ST_STOP]}, 32'h0);
    wsync(IDX_CONTROL_B_SET, 32'h0);
    rd(ad(IDX_CONTROL_B_SET));
    check({31'h0, d[CB_SINGLE_RUN_ENABLE]}, 32'h1);
    wsync(IDX_CONTROL_B_CLR, 32'h4);
    rd(ad(IDX_CONTROL_B_SET));
    check({31'h0, d[CB_SINGLE_RUN_ENABLE]}, 32'h0);
    $display("test one-shot done");
    // Normal PWM, top 0x3f, divider 1: overflow and channel one match events
    wr(IDX_EVENT_CONTROL, 32'h2100);
    wsync(IDX_CC1, 32'h8);
    wsync(IDX_CONTROL_B_SET, 32'h40);
    do @(posedge sys_clk); while (!overflow_event);
    check({31'h0, waveform_output[1]}, 32'h1);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!overflow_event);
    check(n, 32'h40);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!match_event[1]);
    check(n, 32'h9);
    check({31'h0, waveform_output[1]}, 32'h0);
    $display("test pwm done");
    wsync(IDX_CONTROL_C, 32'h10);
    wr(IDX_INT_FLAGS, 32'h33);
    pulse();
    check({31'h0, d[IF_MC_LSB]}, 32'h0);
    wr(IDX_EVENT_CONTROL, 32'h20);
    pulse();
    check({31'h0, d[IF_MC_LSB]}, 32'h1);
    pulse();
    check({31'h0, d[IF_ERR]}, 32'h1);
    $display("test capture done");
    // Pulse-width then period capture: rising edge restarts, falling edge ten cycles on
    wsync(IDX_CONTROL_C, 32'h30);
    wr(IDX_EVENT_CONTROL, 32'h26);
    wr(IDX_INT_FLAGS, 32'h33);
    fire_ev(1'h1);
    repeat (9) @(posedge sys_clk);
    fire_ev(1'h0);
    rd(ad(IDX_CC0));
    check(d, 32'h9);
    rd(ad(IDX_INT_FLAGS));
    check({30'h0, d[IF_MC_LSB +: 2]}, 32'h3);
    $display("test two-edge capture done");
    print_verdict();
  end
endmodule
